// File: logic/four_wire_rtc_host_port.sv
// four-wire serial register port with carry hold-off and daily alarm
`timescale 1ns/100ps
module four_wire_rtc_host_port (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // serial pins
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  // other registers of the device
  output logic [3:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  input wire logic [7:0] reg_rdata_in,
  // seconds carry hold-off
  input wire logic sec_carry_in,
  output logic sec_carry_out,
  // daily alarm
  input wire logic [5:0] cur_hour_in,
  input wire logic [6:0] cur_minute_in,
  output logic alarm_match_out
);
  logic ce_s, sclk_s, si_s;
  logic ce_prev_q;
  logic sclk_prev_q;
  logic ce_rise, ce_fall, sclk_rise, sclk_fall;
  logic sample_edge, launch_edge;
  rtc_port_pkg::port_state_t state_q;
  rtc_port_pkg::port_state_t state_d;
  logic launch_rise_q;
  logic launch_rise_d;
  logic burst_q;
  logic burst_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic so_q;
  logic so_d;
  logic [3:0] addr_q;
  logic [3:0] addr_d;
  logic [3:0] reg_addr_q;
  logic [7:0] reg_wdata_q;
  logic [7:0] reg_wdata_d;
  logic reg_wr_q;
  logic reg_wr_d;
  logic wr_now;
  logic byte_done;
  logic pending_q;
  logic pending_d;
  logic carry_q;
  logic carry_d;
  logic [7:0] rd_byte;
  logic [7:0] alarm_min_rd;
  logic [7:0] alarm_hour_rd;

  // the link clock is sampled, so its period must span several system clocks
  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .async_in({ce_in, sclk_in, si_in}),
    .sync_out({ce_s, sclk_s, si_s})
  );

  assign ce_rise = ce_s && !ce_prev_q;
  assign ce_fall = !ce_s && ce_prev_q;
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign sample_edge = launch_rise_q ? sclk_fall : sclk_rise;
  assign launch_edge = launch_rise_q ? sclk_rise : sclk_fall;
  assign byte_done = sample_edge && (bit_q == rtc_port_pkg::BIT_LAST);

  always_comb begin
    case (addr_q)
      rtc_port_pkg::ADDR_ALARM_MIN: rd_byte = alarm_min_rd;
      rtc_port_pkg::ADDR_ALARM_HOUR: rd_byte = alarm_hour_rd;
      default: rd_byte = reg_rdata_in;
    endcase
  end

  always_comb begin
    state_d = state_q;
    launch_rise_d = launch_rise_q;
    burst_d = burst_q;
    bit_d = bit_q;
    shift_d = shift_q;
    out_d = out_q;
    so_d = so_q;
    addr_d = addr_q;
    reg_wdata_d = reg_wdata_q;
    reg_wr_d = 1'b0;
    wr_now = 1'b0;
    if (ce_rise) begin
      state_d = rtc_port_pkg::ST_CMD;
      bit_d = rtc_port_pkg::BIT_FIRST;
      launch_rise_d = !sclk_s;
    end else if (!ce_s) begin
      state_d = rtc_port_pkg::ST_IDLE;
    end else begin
      case (state_q)
        rtc_port_pkg::ST_CMD: begin
          if (sample_edge) begin
            shift_d = {shift_q[6:0], si_s};
            bit_d = bit_q + 3'h1;
            if (byte_done) begin
              addr_d = shift_d[rtc_port_pkg::CMD_ADDR_MSB:rtc_port_pkg::CMD_ADDR_LSB];
              burst_d = !shift_d[rtc_port_pkg::FMT_SINGLE_BIT];
              state_d = shift_d[rtc_port_pkg::FMT_READ_BIT] ? rtc_port_pkg::ST_RADDR :
                rtc_port_pkg::ST_WDATA;
            end
          end
        end
        rtc_port_pkg::ST_WDATA: begin
          if (sample_edge) begin
            shift_d = {shift_q[6:0], si_s};
            bit_d = bit_q + 3'h1;
            if (byte_done) begin
              wr_now = 1'b1;
              reg_wr_d = (addr_q != rtc_port_pkg::ADDR_ALARM_MIN) &&
                (addr_q != rtc_port_pkg::ADDR_ALARM_HOUR);
              reg_wdata_d = shift_d;
              if (burst_q) begin
                addr_d = addr_q + rtc_port_pkg::ADDR_STEP;
              end else begin
                state_d = rtc_port_pkg::ST_CMD;
              end
            end
          end
        end
        // register address settles one cycle before read data is taken
        rtc_port_pkg::ST_RADDR: state_d = rtc_port_pkg::ST_RLOAD;
        rtc_port_pkg::ST_RLOAD: begin
          out_d = rd_byte;
          state_d = rtc_port_pkg::ST_RDATA;
        end
        rtc_port_pkg::ST_RDATA: begin
          if (launch_edge) begin
            so_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
          end
          if (sample_edge) begin
            bit_d = bit_q + 3'h1;
            if (byte_done) begin
              if (burst_q) begin
                addr_d = addr_q + rtc_port_pkg::ADDR_STEP;
                state_d = rtc_port_pkg::ST_RADDR;
              end else begin
                state_d = rtc_port_pkg::ST_CMD;
              end
            end
          end
        end
        default: state_d = rtc_port_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    pending_d = ce_s && (pending_q || sec_carry_in);
    carry_d = (sec_carry_in && !ce_s) || (ce_fall && pending_q);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= rtc_port_pkg::ST_IDLE;
      ce_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      launch_rise_q <= 1'b1;
      burst_q <= 1'b0;
      bit_q <= rtc_port_pkg::BIT_FIRST;
      shift_q <= 8'h00;
      out_q <= 8'h00;
      so_q <= 1'b0;
      addr_q <= 4'h0;
      reg_addr_q <= 4'h0;
      reg_wdata_q <= 8'h00;
      reg_wr_q <= 1'b0;
      pending_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (clk_en_in) begin
      state_q <= state_d;
      ce_prev_q <= ce_s;
      sclk_prev_q <= sclk_s;
      launch_rise_q <= launch_rise_d;
      burst_q <= burst_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      out_q <= out_d;
      so_q <= so_d;
      addr_q <= addr_d;
      reg_addr_q <= addr_q;
      reg_wdata_q <= reg_wdata_d;
      reg_wr_q <= reg_wr_d;
      pending_q <= pending_d;
      carry_q <= carry_d;
    end
  end

  daily_alarm_regs u_alarm (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .wr_minute_in(wr_now && (addr_q == rtc_port_pkg::ADDR_ALARM_MIN)),
    .wr_hour_in(wr_now && (addr_q == rtc_port_pkg::ADDR_ALARM_HOUR)),
    .wdata_in(shift_d),
    .cur_hour_in(cur_hour_in),
    .cur_minute_in(cur_minute_in),
    .minute_rd_out(alarm_min_rd),
    .hour_rd_out(alarm_hour_rd),
    .match_out(alarm_match_out)
  );

  assign so_out = so_q;
  assign so_oe_out = (state_q == rtc_port_pkg::ST_RDATA);
  assign reg_addr_out = reg_addr_q;
  assign reg_wdata_out = reg_wdata_q;
  assign reg_wr_out = reg_wr_q;
  assign sec_carry_out = carry_q;

  property p_pol_low;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_rise && !sclk_s |=> launch_rise_q;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("polarity not rise launch");
  property p_pol_high;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_rise && sclk_s |=> !launch_rise_q;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("polarity not fall launch");
  property p_close;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_fall |=> (state_q == rtc_port_pkg::ST_IDLE) && !so_oe_out;
  endproperty
  a_close: assert property (p_close) else $error("session not closed");
  property p_cmd_addr;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_s && (state_q == rtc_port_pkg::ST_CMD) && byte_done |=>
        addr_q == $past(shift_d[7:4]);
  endproperty
  a_cmd_addr: assert property (p_cmd_addr) else $error("address not taken");
  property p_burst_wr;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_s && (state_q == rtc_port_pkg::ST_WDATA) && byte_done && burst_q |=>
        addr_q == $past(addr_q) + rtc_port_pkg::ADDR_STEP;
  endproperty
  a_burst_wr: assert property (p_burst_wr) else $error("burst write no step");
  property p_single_wr;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_s && (state_q == rtc_port_pkg::ST_WDATA) && byte_done && !burst_q |=>
        (state_q == rtc_port_pkg::ST_CMD) && (addr_q == $past(addr_q));
  endproperty
  a_single_wr: assert property (p_single_wr) else $error("single write wrong");
  property p_burst_rd;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_s && (state_q == rtc_port_pkg::ST_RDATA) && byte_done && burst_q |=>
        (addr_q == $past(addr_q) + rtc_port_pkg::ADDR_STEP) ##2
        (state_q == rtc_port_pkg::ST_RDATA);
  endproperty
  a_burst_rd: assert property (p_burst_rd) else $error("burst read no step");
  property p_carry_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_s && ce_prev_q && sec_carry_in |=> !sec_carry_out && pending_q;
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry not held");
  property p_carry_free;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      ce_fall && pending_q |=> sec_carry_out ##1 !pending_q;
  endproperty
  a_carry_free: assert property (p_carry_free) else $error("carry not released");
  property p_oe_cmd;
    @(posedge clk_sys_in) disable iff (!reset_n_in || !clk_en_in)
      (state_q == rtc_port_pkg::ST_CMD) || (state_q == rtc_port_pkg::ST_WDATA) |->
        !so_oe_out;
  endproperty
  a_oe_cmd: assert property (p_oe_cmd) else $error("output driven off read");

  c_single_wr: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    reg_wr_out ##[1:400] (state_q == rtc_port_pkg::ST_RDATA));
  c_burst_rd: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_q == rtc_port_pkg::ST_RDATA) && byte_done && burst_q);
  c_carry: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ce_fall && pending_q);
  c_alarm: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(alarm_match_out));
endmodule : four_wire_rtc_host_port

// File: logic/rtc_port_pkg.sv
// constants and types shared by the serial register port of the clock device
package rtc_port_pkg;
  // transfer format codes carried in the low nibble of a command byte
  localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
  localparam logic [3:0] FMT_WR_BURST = 4'h0;
  localparam logic [3:0] FMT_RD_SINGLE = 4'hc;
  localparam logic [3:0] FMT_RD_BURST = 4'h4;
  // format bit positions: bit 3 set means single byte, bit 2 set means read
  localparam int FMT_SINGLE_BIT = 3;
  localparam int FMT_READ_BIT = 2;
  // command byte layout
  localparam int CMD_ADDR_MSB = 7;
  localparam int CMD_ADDR_LSB = 4;
  // byte framing
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [3:0] ADDR_STEP = 4'h1;
  // daily alarm registers
  localparam logic [3:0] ADDR_ALARM_MIN = 4'hb;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'hc;
  localparam int ALARM_MIN_BITS = 7;
  localparam int ALARM_HOUR_BITS = 6;
  localparam logic [6:0] ALARM_MIN_RESET = 7'h00;
  localparam logic [5:0] ALARM_HOUR_RESET = 6'h00;
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WDATA,
    ST_RADDR,
    ST_RLOAD,
    ST_RDATA
  } port_state_t;
endpackage : rtc_port_pkg

// File: logic/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = clk_en_in ? async_in : meta_q;
    sync_d = clk_en_in ? meta_q : sync_q;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : pin_sync

// File: logic/daily_alarm_regs.sv
// daily alarm minute and hour registers with match detection
`timescale 1ns/100ps
module daily_alarm_regs (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // write strobes and data
  input wire logic wr_minute_in,
  input wire logic wr_hour_in,
  input wire logic [7:0] wdata_in,
  // current time from the counters
  input wire logic [5:0] cur_hour_in,
  input wire logic [6:0] cur_minute_in,
  // stored values and match
  output logic [7:0] minute_rd_out,
  output logic [7:0] hour_rd_out,
  output logic match_out
);
  logic [rtc_port_pkg::ALARM_MIN_BITS-1:0] minute_q;
  logic [rtc_port_pkg::ALARM_MIN_BITS-1:0] minute_d;
  logic [rtc_port_pkg::ALARM_HOUR_BITS-1:0] hour_q;
  logic [rtc_port_pkg::ALARM_HOUR_BITS-1:0] hour_d;
  logic match_q;
  logic match_d;

  always_comb begin
    minute_d = minute_q;
    hour_d = hour_q;
    match_d = match_q;
    if (clk_en_in) begin
      if (wr_minute_in) begin
        minute_d = wdata_in[rtc_port_pkg::ALARM_MIN_BITS-1:0];
      end
      if (wr_hour_in) begin
        hour_d = wdata_in[rtc_port_pkg::ALARM_HOUR_BITS-1:0];
      end
      match_d = (cur_hour_in == hour_q) && (cur_minute_in == minute_q);
    end
  end

  // contents cleared to zero at reset, upper bits never stored
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      minute_q <= rtc_port_pkg::ALARM_MIN_RESET;
      hour_q <= rtc_port_pkg::ALARM_HOUR_RESET;
      match_q <= 1'b0;
    end else begin
      minute_q <= minute_d;
      hour_q <= hour_d;
      match_q <= match_d;
    end
  end

  assign minute_rd_out = {1'b0, minute_q};
  assign hour_rd_out = {2'b00, hour_q};
  assign match_out = match_q;
endmodule : daily_alarm_regs

// File: dv/host_link_model.sv
// host side of the four-wire link: enable, shift clock and serial input
`timescale 1ns/100ps
module host_link_model #(
  parameter int HALF_CYC = 16,
  parameter int TIME_GUARD_CYC = 6200,
  parameter int CE_LOW_CYC = 12400
) (
  // clock
  input wire logic clk_sys_in,
  // serial pins
  input wire logic so_in,
  output logic ce_out,
  output logic sclk_out,
  output logic si_out
);
  logic idle_q;
  initial begin
    ce_out = 1'b0;
    sclk_out = 1'b0;
    si_out = 1'b0;
    idle_q = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : wait_cyc
  task automatic start(input logic mode_hi, input bit time_acc);
    idle_q = mode_hi;
    sclk_out = mode_hi;
    wait_cyc(4);
    ce_out = 1'b1;
    wait_cyc(time_acc ? TIME_GUARD_CYC : 8);
  endtask : start
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_out = ~idle_q;
      si_out = tx[i];
      wait_cyc(HALF_CYC);
      rx[i] = so_in;
      sclk_out = idle_q;
      wait_cyc(HALF_CYC);
    end
  endtask : xbyte
  task automatic stop();
    // released input shows the inverse, so a stale bit is never mistaken for data
    si_out = ~si_out;
    ce_out = 1'b0;
    wait_cyc(CE_LOW_CYC);
  endtask : stop
endmodule : host_link_model

// File: dv/testbench.sv
// self-checking bench for the four-wire register port
`timescale 1ns/100ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic sec_carry_in = 1'b0;
  logic clk_en = 1'b1;
  // full low span after a held carry, 62 us at 5 ns
  localparam int CE_LOW_FULL_CYC = 12400;
  logic [5:0] cur_hour = 6'h00;
  logic [6:0] cur_minute = 7'h00;
  logic ce, sclk, si, so, so_oe, reg_wr, carry_out, match;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  wire [7:0] reg_rdata = {reg_addr, ~reg_addr};
  logic [11:0] wq[$];
  logic oe_seen = 1'b0;
  int n_carry = 0;
  int n_errors = 0;
  int n_compared = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  four_wire_rtc_host_port i_dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .ce_in(ce), .sclk_in(sclk), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
    .reg_rdata_in(reg_rdata), .sec_carry_in(sec_carry_in), .sec_carry_out(carry_out),
    .cur_hour_in(cur_hour), .cur_minute_in(cur_minute), .alarm_match_out(match)
  );
  // short gaps where no carry is held; the carry scenario waits the full span
  // an undriven output shows the inverse, so only driven bits read right
  host_link_model #(.CE_LOW_CYC(64)) i_host (
    .clk_sys_in(clk_sys_in), .so_in(so_oe ? so : ~so), .ce_out(ce), .sclk_out(sclk),
    .si_out(si)
  );

  always @(posedge clk_sys_in) begin
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (so_oe === 1'b1) oe_seen <= 1'b1;
    if (carry_out === 1'b1) n_carry++;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_wr(input logic [3:0] a, input logic [7:0] d);
    logic [11:0] w;
    w = (wq.size() != 0) ? wq.pop_front() : 12'hxxx;
    check("write addr", {4'h0, w[11:8]}, {4'h0, a});
    check("write data", w[7:0], d);
  endtask : check_wr
  task automatic wr1(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] rx;
    i_host.xbyte({a, rtc_port_pkg::FMT_WR_SINGLE}, rx);
    i_host.xbyte(d, rx);
  endtask : wr1
  task automatic rd1(input logic [3:0] a, output logic [7:0] d);
    logic [7:0] rx;
    i_host.xbyte({a, rtc_port_pkg::FMT_RD_SINGLE}, rx);
    i_host.xbyte(8'h00, d);
  endtask : rd1

  task automatic t_reset();
    logic [7:0] d;
    check("idle oe", {7'h0, so_oe}, 8'h00);
    i_host.start(1'b0, 1'b0);
    rd1(4'hb, d);
    check("minute reset", d, 8'h00);
    rd1(4'hc, d);
    check("hour reset", d, 8'h00);
    i_host.stop();
  endtask : t_reset
  task automatic t_alarm_rw();
    logic [7:0] d;
    i_host.start(1'b1, 1'b0);
    wr1(4'hb, 8'hd9);
    rd1(4'hb, d);
    check("minute top bit", d, 8'h59);
    wr1(4'hc, 8'he3);
    rd1(4'hc, d);
    check("hour top bits", d, 8'h23);
    i_host.stop();
  endtask : t_alarm_rw
  task automatic t_wr();
    oe_seen = 1'b0;
    i_host.start(1'b0, 1'b1);
    wr1(4'he, 8'ha5);
    wr1(4'h3, 8'h3c);
    i_host.stop();
    check_wr(4'he, 8'ha5);
    check_wr(4'h3, 8'h3c);
    check("oe on writes", {7'h0, oe_seen}, 8'h00);
  endtask : t_wr
  task automatic t_burst_wr();
    logic [7:0] rx;
    i_host.start(1'b1, 1'b1);
    i_host.xbyte({4'he, rtc_port_pkg::FMT_WR_BURST}, rx);
    for (int i = 1; i <= 3; i++) i_host.xbyte(8'(i * 17), rx);
    i_host.stop();
    check_wr(4'he, 8'h11);
    check_wr(4'hf, 8'h22);
    check_wr(4'h0, 8'h33);
  endtask : t_burst_wr
  task automatic t_burst_rd();
    logic [7:0] d;
    logic [3:0] a;
    oe_seen = 1'b0;
    i_host.start(1'b0, 1'b1);
    i_host.xbyte({4'hb, rtc_port_pkg::FMT_RD_BURST}, d);
    for (int i = 0; i < 6; i++) begin
      a = 4'hb + 4'(i);
      i_host.xbyte(8'h00, d);
      check("burst read", d, (a == 4'hb) ? 8'h59 : (a == 4'hc) ? 8'h23 : {a, ~a});
    end
    i_host.stop();
    check("oe on reads", {7'h0, oe_seen}, 8'h01);
  endtask : t_burst_rd
  task automatic pulse_carry();
    sec_carry_in = 1'b1;
    i_host.wait_cyc(1);
    sec_carry_in = 1'b0;
  endtask : pulse_carry
  task automatic t_carry();
    int c0;
    c0 = n_carry;
    clk_en = 1'b0;
    sec_carry_in = 1'b1;
    i_host.wait_cyc(3);
    check("carry frozen", 8'(n_carry - c0), 8'h00);
    clk_en = 1'b1;
    i_host.wait_cyc(1);
    sec_carry_in = 1'b0;
    i_host.wait_cyc(3);
    check("carry after freeze", 8'(n_carry - c0), 8'h01);
    c0 = n_carry;
    pulse_carry();
    i_host.wait_cyc(3);
    check("carry passes", 8'(n_carry - c0), 8'h01);
    i_host.start(1'b1, 1'b0);
    pulse_carry();
    i_host.wait_cyc(40);
    check("carry held", 8'(n_carry - c0), 8'h01);
    i_host.stop();
    check("carry released", 8'(n_carry - c0), 8'h02);
    i_host.wait_cyc(CE_LOW_FULL_CYC);
  endtask : t_carry
  task automatic t_match();
    logic [7:0] hours [2] = '{8'h12, 8'h32};
    foreach (hours[i]) begin
      i_host.start(1'b1, 1'b0);
      wr1(4'hb, 8'h45);
      wr1(4'hc, hours[i]);
      i_host.stop();
      cur_minute = 7'h45;
      cur_hour = hours[i][5:0];
      i_host.wait_cyc(4);
      check("alarm match", {7'h0, match}, 8'h01);
      cur_minute = 7'h46;
      i_host.wait_cyc(4);
      check("alarm differs", {7'h0, match}, 8'h00);
    end
  endtask : t_match

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (3) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    i_host.wait_cyc(3);
    t_reset();
    t_alarm_rw();
    t_wr();
    t_burst_wr();
    t_burst_rd();
    t_carry();
    t_match();
    close_out();
  end
  // expected run is near 203 us
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
endmodule : testbench
